/* hwmon_regs.sv */
// hwmon_regs: identification, second configuration, two fan-control registers, masks and status mirrors.
// assumes a serial-bus front end issuing one-cycle rd/wr requests; read data follows one cycle later.
//
// Notes on behaviour
// (RULE1) register 49h returns the live voltage-code bit four in bit 0 and a fixed identity pattern above it.
// (RULE2) configuration bit 0 keeps thermal interrupts off the interrupt pin but never off the overtemp output; here only while status_one_src[5:4] is 0.
// (RULE3) writing 1 to configuration bit 1 locks fan register 13h until any reset.
// (RULE4) writing 1 to configuration bit 2 locks fan register 14h until any reset.
// (RULE5) configuration bit 3 picks default (0) or ACPI (1) overtemp output mode.
// (RULE6) configuration bit 6 enables aux input A as an active-high interrupt when the shared pins are interrupts.
// (RULE7) configuration bit 7 enables aux input B likewise, resetting to 0.
// (RULE8) mirror one bits 0 to 7 show limit violations of the eight primary channels.
// (RULE9) mirror one bits 4 and 5 also show a set temperature interrupt.
// (RULE10) mirror two bit 0 shows 12 V and bit 1 core supply two violations, bits 2 and 3 reserved.
// (RULE11) mirror two bit 4 shows that the chassis intrusion input went high.
// (RULE12) mirror two bit 5 shows that the overtemp pin was pulled low externally.
// (RULE13) mirror two bits 6 and 7 show remote diode one and two faults.
// (RULE14) host software may mask a persistently interrupting error until it is cured.
// (RULE15) a 1 in a mask bit stops the matching status bit from driving the interrupt pin.
// (RULE16) mirrors carry the same condition bits as the primary status registers.
`timescale 1ns/1ps
module hwmon_regs (
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       soft_reset,
    input  wire hwmon_pkg::hwmon_req_t      req,
    input  wire logic                       cpu_voltage_code_bit_four,
    input  wire logic [7:0]                 status_one_src,
    input  wire logic [7:0]                 status_two_src,
    input  wire hwmon_pkg::hwmon_temp_irq_t temp_irq,
    input  wire logic                       shared_pins_irq_mode,
    input  wire logic                       aux_irq_a_pin,
    input  wire logic                       aux_irq_b_pin,
    output logic [7:0]                      rdata_q,
    output logic [7:0]                      fan_ambient_q,
    output logic [7:0]                      fan_remote_q,
    output logic                            overtemp_signal_q,
    output logic                            overtemp_acpi_mode_q,
    output logic                            int_n_q
);
    logic       any_rst;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] mask_one_q;
    logic [7:0] mask_one_d;
    logic [7:0] mask_two_q;
    logic [7:0] mask_two_d;
    logic [7:0] fan_ambient_d;
    logic [7:0] fan_remote_d;
    logic [7:0] rdata_d;
    logic       overtemp_signal_d;
    logic       aux_req_q;
    logic       aux_req_d;
    logic [7:0] mirror_one;
    logic [7:0] mirror_two;
    logic       overtemp_acpi_mode_d;
    logic       wr_cfg;
    logic       wr_fan_amb;
    logic       wr_fan_rem;
    logic       wr_mask_one;
    logic       wr_mask_two;

    assign any_rst = rst | soft_reset;

    // write strobes, one per writable register
    always_comb begin
        wr_cfg      = 1'b0;
        wr_fan_amb  = 1'b0;
        wr_fan_rem  = 1'b0;
        wr_mask_one = 1'b0;
        wr_mask_two = 1'b0;
        if (req.wr) begin
            if (req.addr == hwmon_pkg::ADDR_CONFIG_TWO) begin
                wr_cfg = 1'b1;
            end else if (req.addr == hwmon_pkg::ADDR_FAN_AMBIENT) begin
                wr_fan_amb = 1'b1;
            end else if (req.addr == hwmon_pkg::ADDR_FAN_REMOTE) begin
                wr_fan_rem = 1'b1;
            end else if (req.addr == hwmon_pkg::ADDR_MASK_ONE) begin
                wr_mask_one = 1'b1;
            end else if (req.addr == hwmon_pkg::ADDR_MASK_TWO) begin
                wr_mask_two = 1'b1;
            end
        end
    end

    // configuration two
    always_comb begin
        cfg_d = cfg_q;
        if (wr_cfg) begin
            cfg_d = req.wdata & hwmon_pkg::CFG_WRITABLE; // RULE5 RULE6 RULE7
            // lock bits only ever set; cleared by reset alone
            cfg_d[hwmon_pkg::CFG_LOCK_AMBIENT] = cfg_q[hwmon_pkg::CFG_LOCK_AMBIENT]
                | req.wdata[hwmon_pkg::CFG_LOCK_AMBIENT]; // RULE3
            cfg_d[hwmon_pkg::CFG_LOCK_REMOTE] = cfg_q[hwmon_pkg::CFG_LOCK_REMOTE]
                | req.wdata[hwmon_pkg::CFG_LOCK_REMOTE]; // RULE4
        end
        overtemp_acpi_mode_d = cfg_d[hwmon_pkg::CFG_OVERTEMP_SIGNAL_ACPI]; // RULE5
    end

    // fan-control registers, each closed by its lock bit
    always_comb begin
        fan_ambient_d = fan_ambient_q;
        fan_remote_d  = fan_remote_q;
        if (wr_fan_amb && !cfg_q[hwmon_pkg::CFG_LOCK_AMBIENT]) begin
            fan_ambient_d = req.wdata; // RULE3
        end
        if (wr_fan_rem && !cfg_q[hwmon_pkg::CFG_LOCK_REMOTE]) begin
            fan_remote_d = req.wdata; // RULE4
        end
    end

    // interrupt masks
    always_comb begin
        mask_one_d = mask_one_q;
        mask_two_d = mask_two_q;
        if (wr_mask_one) begin
            mask_one_d = req.wdata; // RULE15
        end
        if (wr_mask_two) begin
            mask_two_d = req.wdata; // RULE15
        end
    end

    // read data, held until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (req.rd) begin
            if (req.addr == hwmon_pkg::ADDR_VID_IDENT) begin
                rdata_d = {hwmon_pkg::IDENT_PATTERN, cpu_voltage_code_bit_four}; // RULE1
            end else if (req.addr == hwmon_pkg::ADDR_CONFIG_TWO) begin
                rdata_d = cfg_q;
            end else if (req.addr == hwmon_pkg::ADDR_FAN_AMBIENT) begin
                rdata_d = fan_ambient_q;
            end else if (req.addr == hwmon_pkg::ADDR_FAN_REMOTE) begin
                rdata_d = fan_remote_q;
            end else if (req.addr == hwmon_pkg::ADDR_MASK_ONE) begin
                rdata_d = mask_one_q;
            end else if (req.addr == hwmon_pkg::ADDR_MASK_TWO) begin
                rdata_d = mask_two_q;
            end else if (req.addr == hwmon_pkg::ADDR_MIRROR_ONE) begin
                rdata_d = mirror_one; // RULE8 RULE16
            end else if (req.addr == hwmon_pkg::ADDR_MIRROR_TWO) begin
                rdata_d = mirror_two; // RULE10 RULE16
            end else begin
                rdata_d = hwmon_pkg::RST_BYTE;
            end
        end
    end

    always_comb begin
        // overtemp follows thermal events whatever the thermal mask holds
        overtemp_signal_d = temp_irq.int_temp | temp_irq.ext_temp; // RULE2
        aux_req_d = shared_pins_irq_mode
                  & ((cfg_q[hwmon_pkg::CFG_AUX_A_EN] & aux_irq_a_pin)    // RULE6
                   | (cfg_q[hwmon_pkg::CFG_AUX_B_EN] & aux_irq_b_pin));  // RULE7
    end

    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            cfg_q                <= hwmon_pkg::RST_BYTE;
            overtemp_acpi_mode_q <= 1'b0;
        end else begin
            cfg_q                <= cfg_d;
            overtemp_acpi_mode_q <= overtemp_acpi_mode_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            fan_ambient_q <= hwmon_pkg::RST_BYTE;
            fan_remote_q  <= hwmon_pkg::RST_BYTE;
        end else begin
            fan_ambient_q <= fan_ambient_d;
            fan_remote_q  <= fan_remote_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            mask_one_q <= hwmon_pkg::RST_BYTE;
            mask_two_q <= hwmon_pkg::RST_BYTE;
        end else begin
            mask_one_q <= mask_one_d;
            mask_two_q <= mask_two_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            rdata_q <= hwmon_pkg::RST_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            overtemp_signal_q <= 1'b0;
            aux_req_q         <= 1'b0;
        end else begin
            overtemp_signal_q <= overtemp_signal_d;
            aux_req_q         <= aux_req_d;
        end
    end

    hwmon_status_mirror u_mirror (
        .ref_clk        (ref_clk),
        .rst            (any_rst),
        .status_one_src (status_one_src),
        .status_two_src (status_two_src),
        .temp_irq       (temp_irq),
        .mask_one       (mask_one_q),
        .mask_two       (mask_two_q),
        .overtemp_signal_int_mask (cfg_q[hwmon_pkg::CFG_OVERTEMP_SIGNAL_INT_MASK]),
        .aux_irq_req    (aux_req_q),
        .mirror_one_q   (mirror_one),
        .mirror_two_q   (mirror_two),
        .int_n_q        (int_n_q)
    );
endmodule

/* hwmon_pkg.sv */
// hwmon_pkg: offsets, field positions, reset values and carrier types of the monitor register bank.
// assumes a serial-bus front end that turns bus frames into single register requests.
package hwmon_pkg;

    localparam logic [7:0] ADDR_FAN_AMBIENT  = 8'h13;
    localparam logic [7:0] ADDR_FAN_REMOTE   = 8'h14;
    localparam logic [7:0] ADDR_MASK_ONE     = 8'h43;
    localparam logic [7:0] ADDR_MASK_TWO     = 8'h44;
    localparam logic [7:0] ADDR_VID_IDENT    = 8'h49;
    localparam logic [7:0] ADDR_CONFIG_TWO   = 8'h4A;
    localparam logic [7:0] ADDR_MIRROR_ONE   = 8'h4C;
    localparam logic [7:0] ADDR_MIRROR_TWO   = 8'h4D;

    // identification pattern, value arbitrary
    localparam logic [6:0] IDENT_PATTERN     = 7'h2A;

    localparam int CFG_OVERTEMP_SIGNAL_INT_MASK        = 0;
    localparam int CFG_LOCK_AMBIENT          = 1;
    localparam int CFG_LOCK_REMOTE           = 2;
    localparam int CFG_OVERTEMP_SIGNAL_ACPI            = 3;
    localparam int CFG_AUX_A_EN              = 6;
    localparam int CFG_AUX_B_EN              = 7;
    localparam logic [7:0] CFG_WRITABLE      = 8'hCF;

    localparam int ST1_INT_TEMP              = 4;
    localparam int ST1_EXT_TEMP              = 5;
    localparam int ST2_OVERTEMP_SIGNAL_PIN             = 5;
    localparam logic [7:0] ST2_DEFINED       = 8'hF3;

    localparam logic [7:0] RST_BYTE          = 8'h00;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hwmon_req_t;

    typedef struct packed {
        logic       int_temp;
        logic       ext_temp;
    } hwmon_temp_irq_t;

endpackage

/* hwmon_status_mirror.sv */
// hwmon_status_mirror: registers the mirror copies of both status bytes and the masked interrupt output.
// assumes the primary status bytes arrive synchronous to ref_clk.
`timescale 1ns/1ps
module hwmon_status_mirror (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire logic [7:0]               status_one_src,
    input  wire logic [7:0]               status_two_src,
    input  wire hwmon_pkg::hwmon_temp_irq_t temp_irq,
    input  wire logic [7:0]               mask_one,
    input  wire logic [7:0]               mask_two,
    input  wire logic                     overtemp_signal_int_mask,
    input  wire logic                     aux_irq_req,
    output logic [7:0]                    mirror_one_q,
    output logic [7:0]                    mirror_two_q,
    output logic                          int_n_q
);
    logic [7:0] mirror_one_d;
    logic [7:0] mirror_two_d;
    logic [7:0] fire_one;
    logic [7:0] fire_two;
    logic       int_n_d;

    // per-bit mask gating
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            assign fire_one[gi] = mirror_one_d[gi] & ~mask_one[gi]; // RULE15
            assign fire_two[gi] = mirror_two_d[gi] & ~mask_two[gi]; // RULE15
        end
    endgenerate

    always_comb begin
        mirror_one_d = status_one_src; // RULE8 RULE16
        mirror_one_d[hwmon_pkg::ST1_INT_TEMP] = status_one_src[hwmon_pkg::ST1_INT_TEMP] | temp_irq.int_temp; // RULE9
        mirror_one_d[hwmon_pkg::ST1_EXT_TEMP] = status_one_src[hwmon_pkg::ST1_EXT_TEMP] | temp_irq.ext_temp; // RULE9
        // bits 0,1,4,5,6,7 pass; reserved bits read low
        mirror_two_d = status_two_src & hwmon_pkg::ST2_DEFINED; // RULE10 RULE11 RULE12 RULE13 RULE16
        // thermal interrupts reach the interrupt pin unless masked; configuration bit 0 masks them only while status_one_src bits 4 and 5 are clear
        int_n_d = ~((|fire_one) | (|fire_two) | aux_irq_req
                  | (~overtemp_signal_int_mask & ~mask_one[hwmon_pkg::ST1_INT_TEMP] & temp_irq.int_temp)   // RULE2
                  | (~overtemp_signal_int_mask & ~mask_one[hwmon_pkg::ST1_EXT_TEMP] & temp_irq.ext_temp)); // RULE2
        if (overtemp_signal_int_mask) begin
            // status bits driven by thermal interrupts alone are kept off the pin only while status_one_src bits 4 and 5 are both clear
            if (!status_one_src[hwmon_pkg::ST1_INT_TEMP] && !status_one_src[hwmon_pkg::ST1_EXT_TEMP]
                && !((|(fire_one & ~8'h30)) | (|fire_two) | aux_irq_req)) begin
                int_n_d = 1'b1; // RULE2
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mirror_one_q <= hwmon_pkg::RST_BYTE;
            mirror_two_q <= hwmon_pkg::RST_BYTE;
            int_n_q      <= 1'b1;
        end else begin
            mirror_one_q <= mirror_one_d;
            mirror_two_q <= mirror_two_d;
            int_n_q      <= int_n_d;
        end
    end
endmodule

/* hwmon_regs_checker.sv */
// hwmon_regs_checker: port assertions on the monitor register bank.
// assumes a bind to hwmon_regs, one clock domain.
`timescale 1ns/1ps
module hwmon_regs_checker (
    input wire logic                       ref_clk,
    input wire logic                       rst,
    input wire logic                       soft_reset,
    input wire hwmon_pkg::hwmon_req_t      req,
    input wire logic                       cpu_voltage_code_bit_four,
    input wire logic [7:0]                 status_one_src,
    input wire logic [7:0]                 status_two_src,
    input wire hwmon_pkg::hwmon_temp_irq_t temp_irq,
    input wire logic                       shared_pins_irq_mode,
    input wire logic                       aux_irq_a_pin,
    input wire logic                       aux_irq_b_pin,
    input wire logic [7:0]                 rdata_q,
    input wire logic [7:0]                 fan_ambient_q,
    input wire logic [7:0]                 fan_remote_q,
    input wire logic                       overtemp_signal_q,
    input wire logic                       overtemp_acpi_mode_q,
    input wire logic                       int_n_q
);
    logic [7:0] cfg_q;
    logic [7:0] m1_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || soft_reset);
    // shadow of config and first mask
    always_ff @(posedge ref_clk) begin
        if (rst || soft_reset) begin
            cfg_q <= 8'h00;
            m1_q  <= 8'h00;
        end else if (req.wr && req.addr == hwmon_pkg::ADDR_CONFIG_TWO) begin
            cfg_q <= (req.wdata & hwmon_pkg::CFG_WRITABLE) | (cfg_q & 8'h06);
        end else if (req.wr && req.addr == hwmon_pkg::ADDR_MASK_ONE) begin
            m1_q <= req.wdata;
        end
    end
    wire aux_on = shared_pins_irq_mode && ((aux_irq_a_pin && cfg_q[6]) || (aux_irq_b_pin && cfg_q[7]));
    wire quiet  = ((status_one_src & ~m1_q) == 8'h00) && (status_two_src == 8'h00)
                  && (cfg_q[0] || temp_irq == 2'b00) && !aux_on;
    wire wr13   = req.wr && req.addr == hwmon_pkg::ADDR_FAN_AMBIENT;
    property p_ident; req.rd && req.addr == 8'h49 |=> rdata_q[7:1] == hwmon_pkg::IDENT_PATTERN; endproperty
    a_ident: assert property (p_ident) else $error("ident pattern wrong");
    property p_lock_amb; cfg_q[1] && wr13 |=> $stable(fan_ambient_q); endproperty
    a_lock_amb: assert property (p_lock_amb) else $error("locked fan reg changed");
    property p_fan_wr; !cfg_q[1] && wr13 |=> fan_ambient_q == $past(req.wdata); endproperty
    a_fan_wr: assert property (p_fan_wr) else $error("fan reg write lost");
    property p_lock_rem; cfg_q[2] && req.wr && req.addr == 8'h14 |=> $stable(fan_remote_q); endproperty
    a_lock_rem: assert property (p_lock_rem) else $error("locked fan reg changed");
    property p_acpi; req.wr && req.addr == 8'h4A |=> overtemp_acpi_mode_q == $past(req.wdata[3]); endproperty
    a_acpi: assert property (p_acpi) else $error("overtemp mode wrong");
    property p_overtemp; temp_irq != 2'b00 |=> overtemp_signal_q; endproperty
    a_overtemp: assert property (p_overtemp) else $error("overtemp missing");
    property p_quiet; quiet [*3] |-> int_n_q; endproperty
    a_quiet: assert property (p_quiet) else $error("interrupt without source");
    property p_active; ((status_one_src & ~m1_q) != 8'h00) [*3] |-> !int_n_q; endproperty
    a_active: assert property (p_active) else $error("interrupt missing");
endmodule
bind hwmon_regs hwmon_regs_checker u_hwmon_regs_checker (.ref_clk, .rst, .soft_reset, .req,
    .cpu_voltage_code_bit_four, .status_one_src, .status_two_src, .temp_irq, .shared_pins_irq_mode, .aux_irq_a_pin,
    .aux_irq_b_pin, .rdata_q, .fan_ambient_q, .fan_remote_q, .overtemp_signal_q, .overtemp_acpi_mode_q, .int_n_q);

/* hwmon_host_model.sv */
// hwmon_host_model: bus host issuing single register requests.
// assumes requests launch at a rising ref_clk edge.
`timescale 1ns/1ps
module hwmon_host_model (
    input  wire logic            ref_clk,
    input  wire logic [7:0]      rdata_q,
    output hwmon_pkg::hwmon_req_t req
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge ref_clk) req <= '0;
        #1 d = rdata_q;
    endtask
endmodule

/* test_hwmon_regs.sv */
// test_hwmon_regs: directed scenarios for the register bank.
// assumes the host model drives all register requests.
`timescale 1ns/1ps
module test_hwmon_regs;
    logic                       ref_clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       srst = 1'b0;
    logic                       vid = 1'b0;
    logic                       mode = 1'b0;
    logic                       pa = 1'b0;
    logic                       pb = 1'b0;
    logic [7:0]                 s1 = 8'h00;
    logic [7:0]                 s2 = 8'h00;
    logic [7:0]                 rd;
    logic                       int_n;
    logic                       ot;
    logic                       acpi;
    logic [7:0]                 fa;
    logic [7:0]                 fr;
    hwmon_pkg::hwmon_temp_irq_t ti = 2'b00;
    hwmon_pkg::hwmon_req_t      req;
    int                         mismatches = 0;
    int                         num_checks = 0;
    always #10 ref_clk = ~ref_clk;
    hwmon_host_model u_hwmon_host_model (.ref_clk(ref_clk), .rdata_q(rd), .req(req));
    hwmon_regs u_hwmon_regs (.ref_clk(ref_clk), .rst(rst), .soft_reset(srst), .req(req),
        .cpu_voltage_code_bit_four(vid), .status_one_src(s1), .status_two_src(s2), .temp_irq(ti),
        .shared_pins_irq_mode(mode), .aux_irq_a_pin(pa), .aux_irq_b_pin(pb), .rdata_q(rd), .fan_ambient_q(fa),
        .fan_remote_q(fr), .overtemp_signal_q(ot), .overtemp_acpi_mode_q(acpi), .int_n_q(int_n));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_hwmon_host_model.rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_hwmon_host_model.wr(a, d);
    endtask
    task automatic wait3;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_ident;
        rchk("cfg", 8'h4A, 8'h00);
        rchk("unmapped", 8'h50, 8'h00);
        @(posedge ref_clk) vid <= 1'b1;
        rchk("ident", 8'h49, {hwmon_pkg::IDENT_PATTERN, 1'b1});
        @(posedge ref_clk) vid <= 1'b0;
        w(8'h49, 8'hFF);
        rchk("ident", 8'h49, {hwmon_pkg::IDENT_PATTERN, 1'b0});
    endtask
    task automatic t_lock;
        w(8'h13, 8'h5A);
        w(8'h4A, 8'h02);
        w(8'h13, 8'h33);
        w(8'h14, 8'h33);
        w(8'h4A, 8'h00);
        rchk("fan_amb", 8'h13, 8'h5A);
        rchk("fan_rem", 8'h14, 8'h33);
        rchk("cfg", 8'h4A, 8'h02);
        chk("fan_amb_out", 8'h5A, fa);
        chk("fan_rem_out", 8'h33, fr);
        @(posedge ref_clk) srst <= 1'b1;
        @(posedge ref_clk) srst <= 1'b0;
        w(8'h4A, 8'h04);
        w(8'h14, 8'h77);
        w(8'h13, 8'h33);
        rchk("fan_rem", 8'h14, 8'h00);
        rchk("fan_amb", 8'h13, 8'h33);
        chk("fan_amb_out", 8'h33, fa);
        chk("fan_rem_out", 8'h00, fr);
    endtask
    task automatic t_cfg;
        w(8'h4A, 8'hFF);
        rchk("cfg", 8'h4A, hwmon_pkg::CFG_WRITABLE);
        chk("acpi", 8'h01, {7'h00, acpi});
        @(posedge ref_clk) pa <= 1'b1;
        wait3;
        chk("int_n", 8'h01, {7'h00, int_n});
        @(posedge ref_clk) mode <= 1'b1;
        wait3;
        chk("int_n", 8'h00, {7'h00, int_n});
        @(posedge ref_clk) pa <= 1'b0;
        @(posedge ref_clk) pb <= 1'b1;
        wait3;
        chk("int_n", 8'h00, {7'h00, int_n});
        w(8'h4A, 8'h00);
        wait3;
        chk("int_n", 8'h01, {7'h00, int_n});
        chk("acpi", 8'h00, {7'h00, acpi});
        @(posedge ref_clk) pb <= 1'b0;
    endtask
    task automatic t_status;
        @(posedge ref_clk) s1 <= 8'hA5;
        @(posedge ref_clk) s2 <= 8'h5E;
        rchk("mirror1", 8'h4C, 8'hA5);
        rchk("mirror2", 8'h4D, 8'h52);
        chk("int_n", 8'h00, {7'h00, int_n});
        w(8'h43, 8'hFF);
        w(8'h44, 8'hFF);
        wait3;
        chk("int_n", 8'h01, {7'h00, int_n});
        @(posedge ref_clk) s1 <= 8'h5A;
        @(posedge ref_clk) s2 <= 8'hA1;
        rchk("mirror1", 8'h4C, 8'h5A);
        rchk("mirror2", 8'h4D, 8'hA1);
        @(posedge ref_clk) s1 <= 8'h00;
        @(posedge ref_clk) s2 <= 8'h00;
        w(8'h43, 8'h00);
        @(posedge ref_clk) ti <= 2'b10;
        wait3;
        chk("int_n", 8'h00, {7'h00, int_n});
        rchk("mirror1", 8'h4C, 8'h10);
        w(8'h4A, 8'h01);
        @(posedge ref_clk) ti <= 2'b01;
        wait3;
        chk("int_n", 8'h01, {7'h00, int_n});
        chk("overtemp", 8'h01, {7'h00, ot});
        rchk("mirror1", 8'h4C, 8'h20);
        @(posedge ref_clk) ti <= 2'b00;
        wait3;
        chk("overtemp", 8'h00, {7'h00, ot});
        rchk("mirror1", 8'h4C, 8'h00);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_ident;
        t_lock;
        t_cfg;
        t_status;
        results;
    end
endmodule
